/* bench/vlsc_partner.sv */
// vlsc_partner: analog comparator output and free-running low-speed tick.
// assumes mclk_i is the system clock; the tick halts while stop_mode_i is high.
`timescale 1ns/1ps
module vlsc_partner #(
	parameter int HALF = 20
) (
	input  wire logic mclk_i,
	input  wire logic stop_mode_i,
	input  wire logic below_i,
	output logic      tick_16khz_o,
	output logic      cmp_below_o
);
	int cnt_r = 0;

	// a faster tick only shortens every count, spacing scales with it
	always @(posedge mclk_i) begin
		if (!stop_mode_i) begin // sampling clock is stopped in stop mode
			cnt_r <= (cnt_r == 2 * HALF - 1) ? 0 : cnt_r + 1;
		end
	end
	assign tick_16khz_o = (cnt_r >= HALF);
	assign cmp_below_o  = below_i; // no hysteresis modelled, bench sets the level
endmodule // vlsc_partner

/* bench/voltage_level_supervisor_ctl_test.sv */
// voltage_level_supervisor_ctl_test: registers, turn-on timing, actions, stop.
// assumes vlsc_top answers apb with zero waits and the partner drives the tick.
`timescale 1ns/1ps
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", n, x, g); end end
module voltage_level_supervisor_ctl_test;
	import vlsc_pkg::*;
	typedef struct packed {logic w; logic [19:0] a; logic [15:0] d; logic [15:0] x; logic r;} vlsc_row_t;
	localparam logic [19:0] A_CTL  = {2'h0, VLSC_IDX_CONTROL, 2'h0};
	localparam logic [19:0] A_MODE = {2'h0, VLSC_IDX_MODE, 2'h0};
	localparam logic [19:0] A_STAT = {2'h0, VLSC_IDX_STATUS, 2'h0};
	localparam logic [19:0] A_MASK = {2'h0, VLSC_IDX_MASK, 2'h0};
	logic        mclk_i = 1'h0, rst_b_i = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic        stop = 1'h0, below = 1'h0, e, son, svr, svi, irq, pready, pslverr, tick, cmp;
	logic [19:0] paddr = 20'h0;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic [3:0]  thr;
	int          mismatches = 0, total_checks = 0;
	vlsc_row_t   rows [10] = '{'{1'h0, A_CTL, 16'h0, 16'h0, 1'h0}, '{1'h0, A_MODE, 16'h0, 16'h0, 1'h0},
		'{1'h0, A_STAT, 16'h0, 16'h0, 1'h0}, '{1'h0, A_MASK, 16'h0, 16'h0, 1'h0},
		'{1'h1, A_CTL, 16'h06ff, 16'h0, 1'h0}, '{1'h0, A_CTL, 16'h0, 16'h000f, 1'h0},
		'{1'h1, A_MODE, 16'h07ff, 16'h0, 1'h0}, '{1'h0, A_MODE, 16'h0, 16'h0703, 1'h0},
		'{1'h1, 20'h3e420, 16'h00ff, 16'h0, 1'h1}, '{1'h0, 20'h3e420, 16'h0, 16'h0, 1'h1}};

	// 200 MHz system clock
	always #2.5 mclk_i = ~mclk_i;

	vlsc_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .cmp_below_i(cmp),
		.tick_16khz_i(tick), .stop_mode_i(stop), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .supervisor_on_o(son), .threshold_select_o(thr),
		.sv_reset_o(svr), .sv_irq_o(svi), .irq_o(irq));
	vlsc_partner PARTNER (.mclk_i(mclk_i), .stop_mode_i(stop), .below_i(below),
		.tick_16khz_o(tick), .cmp_below_o(cmp));

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task fail;
		mismatches++;
		$display("unexpected timeout");
		test_done;
	endtask

	// setup cycle, then access held until pready is sampled high
	task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		psel   <= 1'h1;
		pen    <= 1'h0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk_i);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) fail;
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen  <= 1'h0;
	endtask

	// counts rising edges of the low-speed tick
	task automatic ticks(input int k, input int settle);
		int n;
		repeat (k) begin
			n = 0;
			while (tick !== 1'h0 && n < 100) begin @(posedge mclk_i); n++; end
			while (tick !== 1'h1 && n < 100) begin @(posedge mclk_i); n++; end
			if (n >= 100) fail;
		end
		repeat (settle) @(posedge mclk_i);
	endtask

	// off, threshold and mode while off, then switch on just after a tick
	task automatic turn_on(input logic [15:0] m, input logic [3:0] t);
		apb(1'h1, A_CTL, {28'h0, t});
		apb(1'h1, A_MODE, {16'h0, m});
		ticks(1, 8);
		apb(1'h1, A_CTL, {28'h0000010, t});
	endtask

	task automatic rdchk(input logic [19:0] a, input logic [15:0] x);
		apb(1'h0, a, 32'h0);
		`CHK("read data", x, q[15:0]);
	endtask

	initial begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'h1;
		repeat (3) @(posedge mclk_i);
		`CHK("supervisor_on_o", 1'h0, son);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, {16'h0, rows[i].d});
			if (!rows[i].w) `CHK("read data", rows[i].x, q[15:0]);
			`CHK("pslverr_o", rows[i].r, e);
		end
		$display("test registers done");
		below <= 1'h1;
		turn_on(16'h0401, 4'h3);
		rdchk(A_CTL, 16'h0103);
		ticks(3, 6);
		rdchk(A_CTL, 16'h0103);
		`CHK("sv_reset_o", 1'h0, svr);
		ticks(1, 6);
		rdchk(A_CTL, 16'h0703);
		`CHK("sv_reset_o", 1'h1, svr);
		`CHK("supervisor_on_o", 1'h1, son);
		`CHK("threshold_select_o", 4'h3, thr);
		apb(1'h1, A_CTL, 32'h3);
		apb(1'h1, A_CTL, 32'h103);
		rdchk(A_CTL, 16'h0103);
		$display("test turn-on done");
		for (int i = 0; i < 4; i++) begin
			turn_on({5'h0, 1'h1, i[0], 7'h0, i[1:0]}, 4'h4);
			ticks(4, 8);
			`CHK("sv_reset_o", i[0], svr);
			`CHK("sv_irq_o", (i == 2), svi);
		end
		`CHK("irq_o", 1'h0, irq);
		apb(1'h1, A_MASK, 32'h1);
		repeat (2) @(posedge mclk_i);
		`CHK("irq_o", 1'h1, irq);
		apb(1'h0, A_STAT, 32'h0);
		`CHK("status ready", 1'h1, q[VLSC_EV_READY]);
		`CHK("status under", 1'h1, q[VLSC_EV_UNDER]);
		repeat (3) @(posedge mclk_i);
		`CHK("irq_o", 1'h0, irq);
		$display("test actions done");
		turn_on(16'h0500, 4'h5);
		ticks(5, 6);
		rdchk(A_CTL, 16'h0105);
		ticks(1, 6);
		rdchk(A_CTL, 16'h0705);
		below <= 1'h0;
		ticks(1, 6);
		rdchk(A_CTL, 16'h0705);
		ticks(1, 6);
		rdchk(A_CTL, 16'h0505);
		$display("test sampling done");
		// stop is entered only once ready has been read as 1
		below <= 1'h1;
		turn_on(16'h0500, 4'h3);
		ticks(6, 6);
		rdchk(A_CTL, 16'h0703);
		below <= 1'h0;
		stop <= 1'h1;
		repeat (300) @(posedge mclk_i);
		rdchk(A_CTL, 16'h0703);
		stop <= 1'h0;
		ticks(1, 6);
		rdchk(A_CTL, 16'h0703);
		ticks(1, 6);
		rdchk(A_CTL, 16'h0503);
		$display("test stop done");
		test_done;
	end
endmodule // voltage_level_supervisor_ctl_test

/* inc/vlsc_pkg.sv */
// vlsc_pkg: register map, field positions, reset values and counts of the
// supply supervisor control block.
// assumes a 32-bit apb slave; printed offsets are word indices (byte = 4 * index).
package vlsc_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [15:0] VLSC_IDX_CONTROL = 16'hf900;
	localparam logic [15:0] VLSC_IDX_MODE    = 16'hf902;
	localparam logic [15:0] VLSC_IDX_STATUS  = 16'hf904;
	localparam logic [15:0] VLSC_IDX_MASK    = 16'hf906;

	// supervisor_control fields
	localparam int VLSC_THR_LSB   = 0;  // threshold_select 3:0
	localparam int VLSC_ON_BIT    = 8;  // supervisor_on
	localparam int VLSC_FLAG_BIT  = 9;  // under_voltage_flag, read only
	localparam int VLSC_READY_BIT = 10; // result_ready_flag, read only

	// supervisor_mode fields
	localparam int VLSC_ACT_LSB  = 0;  // action_select 1:0
	localparam int VLSC_SAMP_BIT = 8;  // sampling_select
	localparam int VLSC_RUN_LSB  = 9;  // running_mode_select 10:9

	// status / mask bits
	localparam int VLSC_EV_READY = 0;  // result became valid
	localparam int VLSC_EV_UNDER = 1;  // under-voltage detected

	// reset values
	localparam logic [3:0]  VLSC_THR_RST  = 4'h0;
	localparam logic [1:0]  VLSC_ACT_RST  = 2'h0;
	localparam logic [1:0]  VLSC_RUN_RST  = 2'h0;
	localparam logic [1:0]  VLSC_MASK_RST = 2'h0;

	// action_select codes
	localparam logic [1:0]  VLSC_ACT_NONE  = 2'h0;
	localparam logic [1:0]  VLSC_ACT_RESET = 2'h1;
	localparam logic [1:0]  VLSC_ACT_IRQ   = 2'h2;
	localparam logic [1:0]  VLSC_ACT_RST2  = 2'h3;

	// tick counts: settle time, extra when sampling
	localparam logic [2:0]  VLSC_SETTLE_TICKS = 3'h4;
	localparam logic [2:0]  VLSC_SAMPLE_TICKS = 3'h2;

endpackage : vlsc_pkg

/* src/vlsc_top.sv */
// vlsc_top: control and status logic of the supply supervisor: apb registers,
// comparator synchroniser, settle counter on the 16 kHz tick, sampling, and
// the reset / interrupt requests toward the chip.
// assumes the comparator and the tick arrive asynchronously; stop_mode_i is on mclk_i.
//
// Operation
// - 4-bit threshold_select in control bits 3:0; codes 3..15 valid, reset 0.
// - supervisor_on at control bit 8 switches the supervisor; resets to off.
// - a supervisor reset leaves supervisor_on set.
// - control and mode registers keep their values across the supervisor reset.
// - read-only under_voltage_flag at control bit 9: 1 while supply is low.
// - switching the supervisor on clears under_voltage_flag.
// - read-only result_ready_flag at control bit 10: 1 once the result is valid.
// - action_select 00 none, 01 reset, 10 interrupt, 11 reset.
// - sampling_select 0 continuous, 1 a sample every two ticks.
// - no sampling while the chip is in stop mode; code holds the flag only with sampling_select 1.
// - sample spacing comes from the low-speed tick.
// - running_mode_select 10 or 11 selects supervisor mode; 00 and 01 prohibited.
// - ready rises four ticks after switch-on, two more with sampling.
// - flag, reset and interrupt stay masked until ready is set; code gates reset and interrupt only.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module vlsc_top
	import vlsc_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [19:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	input  wire logic        cmp_below_i,
	input  wire logic        tick_16khz_i,
	input  wire logic        stop_mode_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             supervisor_on_o,
	output logic      [3:0]  threshold_select_o,
	output logic             sv_reset_o,
	output logic             sv_irq_o,
	output logic             irq_o
);

	typedef struct packed {
		logic [3:0]  thr;
		logic        on;
		logic        flag;
		logic        ready;
		logic [1:0]  act;
		logic        samp;
		logic [1:0]  run;
		logic [2:0]  tcnt;
		logic        scnt;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic        cmp_s1;
		logic        cmp_s2;
		logic        tick_s1;
		logic        tick_s2;
		logic        tick_s3;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        on_out;
		logic [3:0]  thr_out;
		logic        rst_out;
		logic        irq_out;
		logic        int_out;
	} vlsc_state_t;

	vlsc_state_t st_r;
	vlsc_state_t st_nxt;
	logic [1:0]  rst_sync_r;
	logic        rst_b;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_b = rst_sync_r[1];

	// bus decode terms
	logic        acc;
	logic        wr;
	logic        rd;
	logic [15:0] idx;
	logic        hit_ctl;
	logic        hit_mod;
	logic        hit_sts;
	logic        hit_msk;
	logic        mapped;
	logic        tick_edge;
	logic        sv_active;
	logic [2:0]  target;
	logic        turn_on;
	logic [15:0] wdat;

	assign acc       = psel_i && penable_i && st_r.pready;
	assign wr        = acc && pwrite_i;
	assign rd        = acc && !pwrite_i;
	assign idx       = paddr_i[17:2];
	// every hit carries the page check, so a refused address can neither
	// read a register nor clear the status by a read
	assign hit_ctl   = (paddr_i[19:18] == 2'h0) && (idx == VLSC_IDX_CONTROL);
	assign hit_mod   = (paddr_i[19:18] == 2'h0) && (idx == VLSC_IDX_MODE);
	assign hit_sts   = (paddr_i[19:18] == 2'h0) && (idx == VLSC_IDX_STATUS);
	assign hit_msk   = (paddr_i[19:18] == 2'h0) && (idx == VLSC_IDX_MASK);
	assign mapped    = hit_ctl || hit_mod || hit_sts || hit_msk;
	assign wdat      = pwdata_i[15:0];
	// tick edge comes from the second and third stages, never the first
	assign tick_edge = st_r.tick_s2 && !st_r.tick_s3;
	// supervisor mode only with running_mode_select 1x
	assign sv_active = st_r.on && st_r.run[1];
	assign target    = st_r.samp ? 3'(VLSC_SETTLE_TICKS + VLSC_SAMPLE_TICKS)
	                             : VLSC_SETTLE_TICKS;
	// a write of 1 while already on does not restart the judgment
	assign turn_on   = wr && hit_ctl && pstrb_i[1] && wdat[VLSC_ON_BIT] && !st_r.on;

	// next-state logic
	always_comb begin
		st_nxt = st_r;
		// synchronisers: the first stage feeds only the second
		st_nxt.cmp_s1  = cmp_below_i;
		st_nxt.cmp_s2  = st_r.cmp_s1;
		st_nxt.tick_s1 = tick_16khz_i;
		st_nxt.tick_s2 = st_r.tick_s1;
		st_nxt.tick_s3 = st_r.tick_s2;

		// apb: one wait-free access phase, read data prepared in setup
		st_nxt.pready  = psel_i && !penable_i && !st_r.pready;
		st_nxt.pslverr = psel_i && !penable_i && !st_r.pready && !mapped;
		if (psel_i && !penable_i) begin
			st_nxt.prdata = 32'h0;
			if (hit_ctl) begin
				st_nxt.prdata[VLSC_THR_LSB +: 4] = st_r.thr;
				st_nxt.prdata[VLSC_ON_BIT]       = st_r.on;
				st_nxt.prdata[VLSC_FLAG_BIT]     = st_r.flag;
				st_nxt.prdata[VLSC_READY_BIT]    = st_r.ready;
			end else if (hit_mod) begin
				st_nxt.prdata[VLSC_ACT_LSB +: 2] = st_r.act;
				st_nxt.prdata[VLSC_SAMP_BIT]     = st_r.samp;
				st_nxt.prdata[VLSC_RUN_LSB +: 2] = st_r.run;
			end else if (hit_sts) begin
				st_nxt.prdata[1:0] = st_r.status;
			end else if (hit_msk) begin
				st_nxt.prdata[1:0] = st_r.mask;
			end
		end

		// register writes; only rst_b clears these, never the supervisor reset
		if (wr && mapped) begin
			if (hit_ctl && pstrb_i[0]) begin
				st_nxt.thr = wdat[VLSC_THR_LSB +: 4];
			end
			if (hit_ctl && pstrb_i[1]) begin
				st_nxt.on = wdat[VLSC_ON_BIT];
			end
			if (hit_mod && pstrb_i[0]) begin
				st_nxt.act = wdat[VLSC_ACT_LSB +: 2];
			end
			if (hit_mod && pstrb_i[1]) begin
				st_nxt.samp = wdat[VLSC_SAMP_BIT];
				st_nxt.run  = wdat[VLSC_RUN_LSB +: 2];
			end
			if (hit_msk && pstrb_i[0]) begin
				st_nxt.mask = wdat[1:0];
			end
		end

		// settle counting and detection
		if (turn_on) begin
			// fresh judgment: flag and ready restart
			st_nxt.flag  = 1'b0;
			st_nxt.ready = 1'b0;
			st_nxt.tcnt  = 3'h0;
			st_nxt.scnt  = 1'b0;
		end else if (!sv_active) begin
			st_nxt.ready = 1'b0;
			st_nxt.tcnt  = 3'h0;
			st_nxt.scnt  = 1'b0;
		end else if (!st_r.ready) begin
			// ticks halt in stop mode, so the count simply waits
			if (tick_edge && !stop_mode_i) begin
				st_nxt.tcnt = 3'(st_r.tcnt + 3'h1);
				if (3'(st_r.tcnt + 3'h1) == target) begin
					st_nxt.ready = 1'b1;
					st_nxt.flag  = st_r.cmp_s2;
				end
			end
		end else if (!st_r.samp) begin
			st_nxt.flag = st_r.cmp_s2;
		end else if (tick_edge && !stop_mode_i) begin
			// spacing counted in ticks, so it follows the low-speed clock
			st_nxt.scnt = !st_r.scnt;
			if (st_r.scnt) begin
				st_nxt.flag = st_r.cmp_s2;
			end
		end

		// sticky events; a set in the clearing cycle wins
		if (rd && hit_sts) begin
			st_nxt.status = 2'h0;
		end
		if (st_nxt.ready && !st_r.ready) begin
			st_nxt.status[VLSC_EV_READY] = 1'b1;
		end
		if (st_nxt.flag && !st_r.flag && st_nxt.ready) begin
			st_nxt.status[VLSC_EV_UNDER] = 1'b1;
		end

		// registered outputs; requests only once the result is valid
		st_nxt.on_out  = st_r.on;
		st_nxt.thr_out = st_r.thr;
		st_nxt.rst_out = st_r.ready && st_r.flag && st_r.act[0];
		st_nxt.irq_out = st_r.ready && st_r.flag &&
		                 (st_r.act == VLSC_ACT_IRQ);
		st_nxt.int_out = |(st_r.status & st_r.mask);
	end

	// single state register
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			st_r        <= '0;
			st_r.thr    <= VLSC_THR_RST;
			st_r.act    <= VLSC_ACT_RST;
			st_r.run    <= VLSC_RUN_RST;
			st_r.mask   <= VLSC_MASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata_o           = st_r.prdata;
	assign pready_o           = st_r.pready;
	assign pslverr_o          = st_r.pslverr;
	assign supervisor_on_o    = st_r.on_out;
	assign threshold_select_o = st_r.thr_out;
	assign sv_reset_o         = st_r.rst_out;
	assign sv_irq_o           = st_r.irq_out;
	assign irq_o              = st_r.int_out;

	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b);

	turn_on_clear_a: assert property (turn_on |=> !st_r.flag && !st_r.ready)
		else $error("flag or ready not cleared at switch-on");
	off_not_ready_a: assert property (!st_r.on |=> !st_r.ready)
		else $error("ready while supervisor off");
	mask_until_ready_a: assert property (!st_r.ready |=> !sv_reset_o && !sv_irq_o)
		else $error("request before result valid");
	reset_select_a: assert property (sv_reset_o |-> $past(st_r.act[0]) && $past(st_r.flag))
		else $error("reset without reset action");
	irq_select_a: assert property (sv_irq_o |-> $past(st_r.act) == VLSC_ACT_IRQ)
		else $error("interrupt with wrong action");
	cont_track_a: assert property (st_r.ready && sv_active && !st_r.samp && !turn_on
		|=> st_r.flag == $past(st_r.cmp_s2))
		else $error("continuous mode flag not tracking comparator");
	stop_hold_a: assert property (st_r.ready && sv_active && st_r.samp && stop_mode_i
		|=> $stable(st_r.flag))
		else $error("sample taken in stop mode");
	ready_on_tick_a: assert property ($rose(st_r.ready) |-> $past(tick_edge)
		&& $past(st_r.tcnt) == 3'($past(target) - 3'h1))
		else $error("ready without full tick count");
	thr_out_a: assert property (threshold_select_o == $past(st_r.thr))
		else $error("threshold output lags wrongly");
	apb_ready_a: assert property (psel_i && !penable_i && !st_r.pready |=> pready_o)
		else $error("no ready in access phase");
	err_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error response without ready");

	// persistence: only a bus write moves control and mode bits
	keep_on_a: assert property (st_r.on && !(wr && hit_ctl) |=> st_r.on)
		else $error("supervisor switched off without a control write");
	keep_mode_a: assert property (!(wr && hit_mod)
		|=> $stable({st_r.act, st_r.samp, st_r.run}))
		else $error("mode bits changed without a mode write");

	// sticky status and the level interrupt behind it
	sticky_under_a: assert property (st_r.status[VLSC_EV_UNDER] && !(rd && hit_sts)
		|=> st_r.status[VLSC_EV_UNDER])
		else $error("under-voltage status lost without a read");
	int_level_a: assert property (irq_o == $past(|(st_r.status & st_r.mask)))
		else $error("interrupt level does not follow masked status");

	// actions and running mode
	one_action_a: assert property (!(sv_reset_o && sv_irq_o))
		else $error("reset and interrupt requested together");
	ready_mode_a: assert property (st_r.ready |-> $past(st_r.on) && $past(st_r.run[1]))
		else $error("ready outside supervisor mode");

	ready_cov_c: cover property ($rose(st_r.ready) && st_r.samp);
	reset_cov_c: cover property ($rose(sv_reset_o));
	irq_cov_c:   cover property ($rose(sv_irq_o));
	int_cov_c:   cover property ($rose(irq_o));
	stop_cov_c:  cover property (st_r.ready && st_r.samp && stop_mode_i);

endmodule // vlsc_top
